// file: rtl/tcw_map.svh
// Purpose: Offsets, field positions, reset values and counter limits
// Assumes: Included by bare name, registers one byte in lane 0
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef TCW_MAP_SVH
`define TCW_MAP_SVH
`define OFS_CTRL        8'h00
`define OFS_COUNT       8'h04
`define OFS_COMPARE     8'h08
`define OFS_STATUS      8'h0c
`define CTRL_WGM_LSB    0
`define CTRL_COM_LSB    2
`define CTRL_FORCE_BIT  7
`define STAT_OVF_BIT    0
`define STAT_CMF_BIT    1
`define STAT_OCS_BIT    2
`define CNT_MAX         8'hff
`define CNT_BOTTOM      8'h00
`define RST_BYTE        8'h00
`define RST_BIT         1'b0
`endif

// file: rtl/tcw_pkg.sv
// Purpose: Types shared by the timer compare waveform unit
// Assumes: Used by scoped names only
// Notes:   Mode encodings match the two-bit control fields
package tcw_pkg;
  typedef enum logic [1:0] {
    WM_NORMAL = 2'b00,
    WM_PHASE  = 2'b01,
    WM_CTC    = 2'b10,
    WM_FAST   = 2'b11
  } wave_mode_e;
  typedef enum logic [1:0] {
    COM_OFF    = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR  = 2'b10,
    COM_SET    = 2'b11
  } com_mode_e;
  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;
endpackage : tcw_pkg

// file: rtl/timer_compare_waveform_unit.sv
// Purpose: 8-bit timer counter with compare flag, waveform state and pin override
// Assumes: timer_tick is a one-clk enable from the prescaler; pins synchronous
// Notes:   Dual-slope mode counts like normal mode and drives no waveform
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "tcw_map.svh"

module timer_compare_waveform_unit (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Wishbone slave
  input  wire tcw_pkg::wb_req_s wb_req,
  output logic                wb_ack,
  output logic [31:0]         wb_dat_o,
  // Prescaler enable and interrupt service acknowledges
  input  wire logic           timer_tick,
  input  wire logic           ovf_serviced,
  input  wire logic           cmf_serviced,
  // Port pin
  input  wire logic           port_data,
  input  wire logic           pin_direction_bit,
  output logic                pin_out,
  output logic                pin_oe,
  // Flag levels for the interrupt controller
  output logic                overflow_flag,
  output logic                compare_match_flag
);

  tcw_pkg::wave_mode_e waveform_mode_r;
  tcw_pkg::com_mode_e  compare_output_mode_r;
  logic [7:0]          counter_value_r;
  logic [7:0]          compare_value_r;
  logic [7:0]          compare_buf_r;
  logic                overflow_flag_r;
  logic                compare_match_flag_r;
  logic                compare_output_state_r;
  logic                block_r;
  logic                ack_r;
  logic [31:0]         dat_r;
  logic                pin_out_r;
  logic                pin_oe_r;

  logic                access;
  logic                wr_strobe;
  logic                wr_ctrl;
  logic                wr_count;
  logic                wr_compare;
  logic                wr_status;
  logic                is_pwm;
  logic                at_max;
  logic                match;
  logic                force_hit;
  tcw_pkg::com_mode_e  force_com;
  tcw_pkg::wave_mode_e force_wm;
  logic                ovf_set;
  logic                ovf_clr;
  logic                cmf_set;
  logic                cmf_clr;

  // Action of one compare match on the output state
  function automatic logic match_action(input tcw_pkg::com_mode_e com,
                                        input logic cur);
    case (com)
      tcw_pkg::COM_TOGGLE: match_action = ~cur;
      tcw_pkg::COM_CLEAR:  match_action = 1'b0;
      tcw_pkg::COM_SET:    match_action = 1'b1;
      default:             match_action = cur;
    endcase
  endfunction : match_action

  // Bus decode: taken while ack is low; a write lands at the edge where ack is high,
  // so it takes effect exactly when the master sees the answer and not a cycle early
  assign access     = wb_req.cyc & wb_req.stb & ~ack_r;
  assign wr_strobe  = wb_req.cyc & wb_req.stb & ack_r & wb_req.we & wb_req.sel[0];
  assign wr_ctrl    = wr_strobe & (wb_req.adr == `OFS_CTRL);
  assign wr_count   = wr_strobe & (wb_req.adr == `OFS_COUNT);
  assign wr_compare = wr_strobe & (wb_req.adr == `OFS_COMPARE);
  assign wr_status  = wr_strobe & (wb_req.adr == `OFS_STATUS);

  // Compare and limit detection
  assign is_pwm = waveform_mode_r[0];
  assign at_max = (counter_value_r == `CNT_MAX);
  // A counter write suppresses matches until the next tick
  assign match  = (counter_value_r == compare_value_r) & ~block_r;

  // Force uses the mode bits written alongside the strobe
  assign force_com = tcw_pkg::com_mode_e'(wb_req.dat[`CTRL_COM_LSB +: 2]);
  assign force_wm  = tcw_pkg::wave_mode_e'(wb_req.dat[`CTRL_WGM_LSB +: 2]);
  assign force_hit = wr_ctrl & wb_req.dat[`CTRL_FORCE_BIT] & ~force_wm[0];

  // Flag events; dual-slope overflow is not modelled
  assign ovf_set = timer_tick & at_max & ~wr_count
                 & (waveform_mode_r != tcw_pkg::WM_PHASE);
  assign cmf_set = timer_tick & match;
  assign ovf_clr = ovf_serviced | (wr_status & wb_req.dat[`STAT_OVF_BIT]);
  assign cmf_clr = cmf_serviced | (wr_status & wb_req.dat[`STAT_CMF_BIT]);

  // Bus answer: one wait-free ack, dropped the cycle after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end

  // Read data captured with the ack; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dat_r <= 32'h0000_0000;
    end else if (access & ~wb_req.we) begin
      case (wb_req.adr)
        `OFS_CTRL:    dat_r <= {28'h000_0000, compare_output_mode_r, waveform_mode_r};
        `OFS_COUNT:   dat_r <= {24'h00_0000, counter_value_r};
        `OFS_COMPARE: dat_r <= {24'h00_0000, compare_buf_r};
        `OFS_STATUS:  dat_r <= {29'h0000_0000, compare_output_state_r,
                                compare_match_flag_r, overflow_flag_r};
        default:      dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // Mode fields act at once; the force bit is a strobe and reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waveform_mode_r       <= tcw_pkg::WM_NORMAL;
      compare_output_mode_r <= tcw_pkg::COM_OFF;
    end else if (wr_ctrl) begin
      waveform_mode_r       <= force_wm;
      compare_output_mode_r <= force_com;
    end
  end

  // Counter: software write has priority over any count or clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_value_r <= `RST_BYTE;
    end else if (wr_count) begin
      counter_value_r <= wb_req.dat[7:0];
    end else if (timer_tick) begin
      if (waveform_mode_r == tcw_pkg::WM_CTC && match) begin
        counter_value_r <= `CNT_BOTTOM;
      end else begin
        // Plain 8-bit increment wraps past max in every mode
        counter_value_r <= counter_value_r + 8'h01;
      end
    end
  end

  // Match blocking window after a counter write, even when stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_r <= `RST_BIT;
    end else if (wr_count) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // Compare value: direct in non-PWM, via buffer at top in PWM
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_value_r <= `RST_BYTE;
      compare_buf_r   <= `RST_BYTE;
    end else begin
      if (wr_compare) begin
        compare_buf_r <= wb_req.dat[7:0];
      end
      if (wr_compare && !is_pwm) begin
        compare_value_r <= wb_req.dat[7:0];
      end else if (is_pwm && timer_tick && at_max) begin
        // Late writes wait for top so no odd-length pulse appears
        compare_value_r <= compare_buf_r;
      end
    end
  end

  // Overflow flag; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow_flag_r <= `RST_BIT;
    end else if (ovf_set) begin
      overflow_flag_r <= 1'b1;
    end else if (ovf_clr) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // Compare match flag; forced compares never reach it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_match_flag_r <= `RST_BIT;
    end else if (cmf_set) begin
      compare_match_flag_r <= 1'b1;
    end else if (cmf_clr) begin
      compare_match_flag_r <= 1'b0;
    end
  end

  // Compare output state; independent of the pin so it can be preset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_output_state_r <= `RST_BIT;
    end else if (force_hit) begin
      compare_output_state_r <= match_action(force_com, compare_output_state_r);
    end else if (timer_tick) begin
      case (waveform_mode_r)
        tcw_pkg::WM_NORMAL,
        tcw_pkg::WM_CTC: begin
          if (match) begin
            compare_output_state_r <=
              match_action(compare_output_mode_r, compare_output_state_r);
          end
        end
        tcw_pkg::WM_FAST: begin
          // Bottom wins over a match at max, giving the constant level
          if (at_max && compare_output_mode_r[1]) begin
            compare_output_state_r <=
              (compare_output_mode_r == tcw_pkg::COM_CLEAR);
          end else if (match) begin
            compare_output_state_r <=
              match_action(compare_output_mode_r, compare_output_state_r);
          end
        end
        default: begin
          compare_output_state_r <= compare_output_state_r;
        end
      endcase
    end
  end

  // Pin: value source chosen by output mode only, direction by the port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_r <= `RST_BIT;
      pin_oe_r  <= `RST_BIT;
    end else begin
      pin_out_r <= (compare_output_mode_r != tcw_pkg::COM_OFF)
                   ? compare_output_state_r : port_data;
      pin_oe_r  <= pin_direction_bit;
    end
  end

  assign wb_ack             = ack_r;
  assign wb_dat_o           = dat_r;
  assign pin_out            = pin_out_r;
  assign pin_oe             = pin_oe_r;
  assign overflow_flag      = overflow_flag_r;
  assign compare_match_flag = compare_match_flag_r;

  // Checks on the waveform and flag logic
  a_reset_state_zero: assert property (@(posedge clk)
    $fell(rst) |-> (compare_output_state_r == 1'b0))
    else $error("output state not zero after reset");

  a_pin_from_state: assert property (@(posedge clk) disable iff (rst)
    (compare_output_mode_r != tcw_pkg::COM_OFF) |=> (pin_out == $past(compare_output_state_r)))
    else $error("pin not driven from output state");

  a_pin_from_port: assert property (@(posedge clk) disable iff (rst)
    (compare_output_mode_r == tcw_pkg::COM_OFF) |=> (pin_out == $past(port_data)))
    else $error("pin not driven from port data");

  a_pin_direction: assert property (@(posedge clk) disable iff (rst)
    $rose(pin_oe) |-> $past(pin_direction_bit))
    else $error("pin enable without direction bit");

  a_mode_off_hold: assert property (@(posedge clk) disable iff (rst)
    (timer_tick && compare_output_mode_r == tcw_pkg::COM_OFF && !force_hit)
    |=> $stable(compare_output_state_r))
    else $error("output state moved with mode off");

  a_normal_wrap: assert property (@(posedge clk) disable iff (rst)
    (waveform_mode_r == tcw_pkg::WM_NORMAL && timer_tick && at_max && !wr_count)
    |=> (counter_value_r == 8'h00) && overflow_flag_r)
    else $error("normal mode wrap or overflow wrong");

  a_ctc_clear: assert property (@(posedge clk) disable iff (rst)
    (waveform_mode_r == tcw_pkg::WM_CTC && timer_tick && match && !wr_count)
    |=> (counter_value_r == 8'h00) && compare_match_flag_r)
    else $error("clear on compare failed");

  a_match_flag: assert property (@(posedge clk) disable iff (rst)
    (timer_tick && match) |=> compare_match_flag_r)
    else $error("match flag not set");

  a_force_no_flag: assert property (@(posedge clk) disable iff (rst)
    (force_hit && !timer_tick && !compare_match_flag_r)
    |=> !compare_match_flag_r && $stable(counter_value_r))
    else $error("forced compare touched flag or counter");

  a_fast_bottom_set: assert property (@(posedge clk) disable iff (rst)
    (waveform_mode_r == tcw_pkg::WM_FAST && timer_tick && at_max && !force_hit
     && compare_output_mode_r == tcw_pkg::COM_CLEAR) |=> compare_output_state_r)
    else $error("fast mode bottom did not set output");

  a_ocr_direct: assert property (@(posedge clk) disable iff (rst)
    (wr_compare && !is_pwm) |=> (compare_value_r == $past(wb_req.dat[7:0])))
    else $error("compare value not written directly");

  a_ocr_buffered: assert property (@(posedge clk) disable iff (rst)
    (is_pwm && !(timer_tick && at_max) && !wr_ctrl) |=> $stable(compare_value_r))
    else $error("compare value changed away from top");

  a_ctc_overflow: assert property (@(posedge clk) disable iff (rst)
    (waveform_mode_r == tcw_pkg::WM_CTC && timer_tick && at_max && !wr_count)
    |=> overflow_flag_r)
    else $error("clear on compare overflow not set");

  a_fast_top_wrap: assert property (@(posedge clk) disable iff (rst)
    (waveform_mode_r == tcw_pkg::WM_FAST && timer_tick && at_max && !wr_count)
    |=> (counter_value_r == 8'h00) && overflow_flag_r)
    else $error("fast mode top wrap or overflow wrong");

  a_state_tick_only: assert property (@(posedge clk) disable iff (rst)
    (!timer_tick && !force_hit) |=> $stable(compare_output_state_r))
    else $error("output state moved without a tick");

  a_count_tick_only: assert property (@(posedge clk) disable iff (rst)
    (!timer_tick && !wr_count) |=> $stable(counter_value_r))
    else $error("counter moved without a tick or write");

endmodule : timer_compare_waveform_unit

// file: test/port_pin_model.sv
// Purpose: Port pin and direction register model facing the timer pin override
// Assumes: The pin carries a pull-up, so a released pin reads high
// Notes:   Levels follow the bench requests with no delay
`timescale 1ns/1ps

module port_pin_model (
  // Requests from the bench
  input  wire logic dir_req,
  input  wire logic data_req,
  // Pin side of the timer
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      port_data,
  output logic      pin_direction_bit,
  output logic      pin_level
);
  // Direction and port data are plain register levels
  assign pin_direction_bit = dir_req;
  assign port_data         = data_req;
  // A released pin never shows the last driven value, only the pull-up
  assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : port_pin_model

// file: test/timer_compare_waveform_unit_test.sv
// Purpose: Self-checking bench for the timer compare waveform unit
// Assumes: Bus answers within a few cycles; timer ticks made by the bench
// Notes:   Reads note their expected byte in a queue, a monitor compares at ack
`timescale 1ns/1ps
`include "tcw_map.svh"

module timer_compare_waveform_unit_test;
  logic             clk, rst, timer_tick, ovf_serviced, cmf_serviced;
  logic             dir_req, data_req, port_data, pin_direction_bit, pin_level;
  logic             wb_ack, pin_out, pin_oe, overflow_flag, compare_match_flag;
  tcw_pkg::wb_req_s wb_req;
  logic [31:0]      wb_dat_o;
  logic [31:0]      lfsr_r;
  logic [7:0]       exp_q[$];
  logic             st;
  logic [1:0]       fc[4] = '{2'd3, 2'd2, 2'd1, 2'd1};
  int               n_fail, cmp_count;

  timer_compare_waveform_unit dut_u (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .timer_tick(timer_tick), .ovf_serviced(ovf_serviced),
    .cmf_serviced(cmf_serviced), .port_data(port_data), .pin_direction_bit(pin_direction_bit),
    .pin_out(pin_out), .pin_oe(pin_oe), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag));
  port_pin_model pin_u (.dir_req(dir_req), .data_req(data_req), .pin_out(pin_out),
    .pin_oe(pin_oe), .port_data(port_data), .pin_direction_bit(pin_direction_bit),
    .pin_level(pin_level));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic fail_msg(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail_msg

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) fail_msg("pin or flag level mismatch");
  endtask : chk_bit

  // Oldest expected read byte against the data taken with ack
  task automatic chk_rd(input logic [31:0] got);
    cmp_count++;
    if (exp_q.size() == 0) fail_msg("read without expected value");
    else if (got !== {24'h0, exp_q.pop_front()}) fail_msg("read data mismatch");
  endtask : chk_rd

  // Monitor: read data is taken at the edge where ack is sampled high
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0) begin
      chk_rd(wb_dat_o);
    end
  end

  // Classic cycle; a read passes its expected byte in d
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    if (!w) exp_q.push_back(d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_msg("ack timeout");
      summarize();
    end
    wb_req <= '0;
    @(posedge clk);
  endtask : wb

  task automatic tick(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      @(posedge clk);
    end
  endtask : tick

  // Pin is registered, so let the override settle before looking
  task automatic pin(input logic e);
    repeat (3) @(posedge clk);
    chk_bit(pin_level, e);
  endtask : pin

  task automatic svc(input logic o);
    if (o) ovf_serviced <= 1'b1;
    else cmf_serviced <= 1'b1;
    @(posedge clk);
    ovf_serviced <= 1'b0;
    cmf_serviced <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : svc

  // Watchdog against a hung run
  initial begin
    #(100 * 50000);
    fail_msg("run timeout");
    summarize();
  end

  initial begin
    rst = 1'b1;
    {timer_tick, ovf_serviced, cmf_serviced, dir_req, data_req} = 5'h00;
    wb_req = '0;
    lfsr_r = 32'h4bea6d35;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, `OFS_STATUS, 8'h00);
    wb(1'b0, `OFS_COUNT, 8'h00);
    wb(1'b0, 8'h10, 8'h00);
    // Forced compares while the pin is released
    st = 1'b0;
    foreach (fc[i]) begin
      wb(1'b1, `OFS_CTRL, {4'h8, fc[i], 2'b00});
      st = (fc[i] == 2'd1) ? ~st : fc[i][0];
      wb(1'b0, `OFS_STATUS, {5'h0, st, 2'b00});
    end
    wb(1'b0, `OFS_COUNT, 8'h00);
    chk_bit(pin_level, 1'b1);
    // Normal mode counting, random count write
    wb(1'b1, `OFS_CTRL, 8'h00);
    lfsr_r = lfsr_next(lfsr_r);
    wb(1'b1, `OFS_COUNT, lfsr_r[7:0]);
    wb(1'b0, `OFS_COUNT, lfsr_r[7:0]);
    wb(1'b1, `OFS_COUNT, 8'hfe);
    tick(2);
    wb(1'b0, `OFS_COUNT, 8'h00);
    chk_bit(overflow_flag, 1'b1);
    tick(1);
    wb(1'b0, `OFS_STATUS, 8'h03);
    svc(1'b0);
    chk_bit(compare_match_flag, 1'b0);
    wb(1'b1, `OFS_STATUS, 8'h01);
    wb(1'b0, `OFS_STATUS, 8'h00);
    // Clear-on-compare with toggle, pin driven
    dir_req <= 1'b1;
    wb(1'b1, `OFS_CTRL, 8'h06);
    wb(1'b1, `OFS_COMPARE, 8'h02);
    wb(1'b1, `OFS_COUNT, 8'h00);
    for (int i = 0; i < 2; i++) begin
      tick(3);
      st = ~st;
      wb(1'b0, `OFS_COUNT, 8'h00);
      wb(1'b0, `OFS_STATUS, {5'h0, st, 2'b10});
      pin(st);
    end
    wb(1'b1, `OFS_STATUS, 8'h03);
    wb(1'b1, `OFS_COUNT, 8'hfe);
    tick(5);
    st = ~st;
    wb(1'b0, `OFS_STATUS, {5'h0, st, 2'b11});
    // Fast PWM, non-inverting then inverting
    for (int c = 2; c < 4; c++) begin
      wb(1'b1, `OFS_CTRL, {4'h0, c[1:0], 2'b11});
      wb(1'b1, `OFS_COMPARE, 8'h10);
      wb(1'b1, `OFS_STATUS, 8'h03);
      wb(1'b1, `OFS_COUNT, 8'hfe);
      tick(2);
      wb(1'b0, `OFS_STATUS, {5'h0, c == 2, 2'b01});
      tick(17);
      wb(1'b0, `OFS_STATUS, {5'h0, c == 3, 2'b11});
      pin(c == 3);
    end
    svc(1'b1);
    chk_bit(overflow_flag, 1'b0);
    // Fast PWM toggle: a new compare waits in the buffer until top
    wb(1'b1, `OFS_CTRL, 8'h07);
    wb(1'b1, `OFS_COMPARE, 8'h05);
    wb(1'b1, `OFS_STATUS, 8'h03);
    wb(1'b1, `OFS_COUNT, 8'h03);
    tick(3);
    wb(1'b0, `OFS_STATUS, 8'h04);
    tick(11);
    wb(1'b0, `OFS_STATUS, 8'h02);
    // Compare at max holds the bottom level; compare at zero gives a one-tick spike
    wb(1'b1, `OFS_COMPARE, 8'hff);
    wb(1'b1, `OFS_CTRL, 8'h0b);
    wb(1'b1, `OFS_COUNT, 8'hfe);
    tick(2);
    wb(1'b1, `OFS_STATUS, 8'h03);
    wb(1'b1, `OFS_COUNT, 8'hfe);
    tick(2);
    wb(1'b0, `OFS_STATUS, 8'h07);
    pin(1'b1);
    wb(1'b1, `OFS_COMPARE, 8'h00);
    wb(1'b1, `OFS_COUNT, 8'hfe);
    tick(2);
    wb(1'b0, `OFS_STATUS, 8'h07);
    tick(1);
    wb(1'b0, `OFS_STATUS, 8'h03);
    // Dual-slope select only counts here: no overflow and no waveform action
    wb(1'b1, `OFS_CTRL, 8'h09);
    wb(1'b1, `OFS_STATUS, 8'h03);
    wb(1'b1, `OFS_COUNT, 8'hfe);
    tick(2);
    wb(1'b0, `OFS_COUNT, 8'h00);
    wb(1'b0, `OFS_STATUS, 8'h00);
    // Output mode off hands the pin back to port data
    wb(1'b1, `OFS_CTRL, 8'h03);
    repeat (4) begin
      lfsr_r = lfsr_next(lfsr_r);
      data_req <= lfsr_r[0];
      pin(lfsr_r[0]);
    end
    dir_req <= 1'b0;
    pin(1'b1);
    summarize();
  end
endmodule : timer_compare_waveform_unit_test
